// ===== pfrm_consts.svh
// Constants of the power fault response manager: offsets, fields, timing.
`ifndef PFRM_CONSTS_SVH
`define PFRM_CONSTS_SVH
// ----------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------
`define PFRM_OFF_CTRL  8'h00
`define PFRM_OFF_UVCFG 8'h04
`define PFRM_OFF_OVCFG 8'h08
`define PFRM_OFF_OCCFG 8'h0C
`define PFRM_OFF_VSET  8'h10
`define PFRM_OFF_STAT  8'h14
// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define PFRM_F_EN      0
`define PFRM_F_UVOVR   1
`define PFRM_F_MODE    0
`define PFRM_F_LIM     4
`define PFRM_F_DLY     8
`define PFRM_F_UVSET   16
`define PFRM_F_TGT     0
`define PFRM_F_PCT     16
// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define PFRM_RST_CTRL  32'h0000_0000
`define PFRM_RST_FCFG  32'h0000_0000
`define PFRM_RST_VSET  32'h000F_0400
`define PFRM_RST_DT    4'h4
// ----------------------------------------------------------------------
// Thresholds in 10 mV steps and limits.
// ----------------------------------------------------------------------
`define PFRM_UV_LO     11'h12C
`define PFRM_UV_OPEN   11'h1C2
`define PFRM_UV_HI     11'h438
`define PFRM_UV_MIN    11'h11D
`define PFRM_UV_MAX    11'h640
`define PFRM_PCT_DIV   20'h0_0064
`define PFRM_DT_MIN    4'h1
`define PFRM_DT_MAX    4'h8
// ----------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------
`define PFRM_CLK_MHZ   40
`define PFRM_TON_US    5000
`define PFRM_RAMP_US   5000
`endif

// ===== pfrm_pkg.sv
// Types of the power fault response manager.
package pfrm_pkg;
  // Main sequencer states, one-hot.
  typedef enum logic [6:0] {
    PFRM_OFF    = 7'b000_0001,
    PFRM_SAMPLE = 7'b000_0010,
    PFRM_DELAY  = 7'b000_0100,
    PFRM_RAMP   = 7'b000_1000,
    PFRM_RUN    = 7'b001_0000,
    PFRM_SHUT   = 7'b010_0000,
    PFRM_LATCH  = 7'b100_0000
  } pfrm_state_e;
  // Fault responses.
  typedef enum logic [2:0] {
    PFRM_R_IMM     = 3'h0,
    PFRM_R_IGNORE  = 3'h1,
    PFRM_R_DELAY   = 3'h2,
    PFRM_R_RETRYN  = 3'h3,
    PFRM_R_RETRYI  = 3'h4,
    PFRM_R_CROWBAR = 3'h5
  } pfrm_resp_e;
  // Per-fault configuration.
  typedef struct packed {
    pfrm_resp_e  mode;
    logic [3:0]  lim;
    logic [7:0]  dly;
  } pfrm_fcfg_s;
endpackage

// ===== pfrm_top.sv
// Power fault response manager: sequencer, fault engine, gate drive, APB.
//
// Operation
// - High and low gates never on together.
// - Dead time tuned in loop to minimise duty.
// - Strap low/open/high gives 3/4.5/10.8 V.
// - Strap resistor picks tabulated 2.85-16 V threshold.
// - Serial setting overrides strap threshold.
// - Ignore mode keeps regulating through undervoltage.
// - Delayed mode runs, then shuts, stays off.
// - Immediate mode stops until clear, then restarts without limit.
// - Default undervoltage: shut, restart when clear.
// - Overvoltage above target plus 15% drops power good.
// - Crowbar: high off, low on until restart.
// - Default overvoltage: shut, restart when clear.
// - Sample output before any ramp.
// - Low pre-bias becomes starting target, then ramp.
// - Ramp time from delay end is fixed.
// - High pre-bias held, power good, then down.
// - Pre-bias above limit skips start, overvoltage fault.
// - Overcurrent retry unlimited or counted, with delay.
// - Overcurrent delayed off, ignore or immediate.
// - Default overcurrent: shut, restart when clear.
`timescale 1ns/10ps
`include "pfrm_consts.svh"
module pfrm_top
  import pfrm_pkg::*;
#(
  parameter int TON_CYC  = `PFRM_TON_US * `PFRM_CLK_MHZ,
  parameter int RAMP_CYC = `PFRM_RAMP_US * `PFRM_CLK_MHZ
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  input_undervoltage_threshold_strap,
  input  wire logic [4:0]  strap_res_idx,
  input  wire logic        uv_fault_in,
  input  wire logic        oc_fault_in,
  input  wire logic [11:0] output_sense_input,
  input  wire logic        pwm_req,
  output logic             hs_gate,
  output logic             ls_gate,
  output logic             power_good_output,
  output logic      [11:0] ref_target,
  output logic      [10:0] uv_threshold
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Resistor strap index to threshold; indices past the table give 16 V.
  function automatic logic [10:0] res_thr(input logic [4:0] i);
    case (i)
      5'h00: res_thr = `PFRM_UV_MIN;
      5'h01: res_thr = 11'h13A;
      5'h02: res_thr = 11'h158;
      5'h03: res_thr = 11'h17B;
      5'h04: res_thr = 11'h1A2;
      5'h05: res_thr = 11'h1CB;
      5'h06: res_thr = 11'h1FA;
      5'h07: res_thr = 11'h22D;
      5'h08: res_thr = 11'h265;
      5'h09: res_thr = 11'h2A3;
      5'h0A: res_thr = 11'h2E6;
      5'h0B: res_thr = 11'h332;
      5'h0C: res_thr = 11'h383;
      5'h0D: res_thr = 11'h3DE;
      5'h0E: res_thr = 11'h442;
      5'h0F: res_thr = 11'h4B0;
      5'h10: res_thr = 11'h528;
      5'h11: res_thr = 11'h5AE;
      default: res_thr = `PFRM_UV_MAX;
    endcase
  endfunction

  // Unpack a fault configuration register.
  function automatic pfrm_fcfg_s cfg_of(input logic [31:0] r);
    cfg_of.mode = pfrm_resp_e'(r[`PFRM_F_MODE +: 3]);
    cfg_of.lim  = r[`PFRM_F_LIM +: 4];
    cfg_of.dly  = r[`PFRM_F_DLY +: 8];
  endfunction

  // A present fault trips now unless ignored or still inside its delay.
  function automatic logic trips(input logic f, input pfrm_fcfg_s c,
                                 input logic [7:0] d);
    trips = f && (c.mode != PFRM_R_IGNORE) &&
            ((c.mode != PFRM_R_DELAY) || (d >= c.dly));
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [20:0] sync1_ff;
  logic [20:0] sync2_ff;
  // Strap, fault and sense pins pass two flops; only the second stage is read.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= 21'h00_0000;
      sync2_ff <= 21'h00_0000;
    end else begin
      sync1_ff <= {input_undervoltage_threshold_strap, strap_res_idx,
                   uv_fault_in, oc_fault_in, output_sense_input};
      sync2_ff <= sync1_ff;
    end
  end
  wire logic [1:0]  s_lvl = sync2_ff[20:19];
  wire logic [4:0]  s_idx = sync2_ff[18:14];
  wire logic        uv_f  = sync2_ff[13];
  wire logic        oc_f  = sync2_ff[12];
  wire logic [11:0] vs    = sync2_ff[11:0];

  // ----------------------------------------------------------------------
  // Registers and APB slave
  // ----------------------------------------------------------------------
  logic [1:0]  ctrl_ff;
  logic [31:0] uvc_ff;
  logic [31:0] ovc_ff;
  logic [31:0] occ_ff;
  logic [31:0] vset_ff;
  logic [31:0] prdata_ff;
  logic [31:0] stat_w;
  // Address decode; writes land only in the access phase.
  wire logic a_ctrl = paddr == `PFRM_OFF_CTRL;
  wire logic a_uv   = paddr == `PFRM_OFF_UVCFG;
  wire logic a_ov   = paddr == `PFRM_OFF_OVCFG;
  wire logic a_oc   = paddr == `PFRM_OFF_OCCFG;
  wire logic a_vset = paddr == `PFRM_OFF_VSET;
  wire logic a_stat = paddr == `PFRM_OFF_STAT;
  wire logic a_hit  = a_ctrl | a_uv | a_ov | a_oc | a_vset | a_stat;
  wire logic wr     = psel & penable & pwrite & a_hit;
  wire logic [31:0] rd_mux =
    a_ctrl ? {30'h0000_0000, ctrl_ff} :
    a_uv   ? uvc_ff  : a_ov   ? ovc_ff  : a_oc ? occ_ff :
    a_vset ? vset_ff : a_stat ? stat_w  : 32'h0000_0000;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~a_hit;
  assign prdata  = prdata_ff;

  // Read data is captured in the setup phase so it comes from a flop.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_ff <= rd_mux;
    end
  end

  // Configuration registers; each fault keeps its own field.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= 2'(`PFRM_RST_CTRL);
      uvc_ff  <= `PFRM_RST_FCFG;
      ovc_ff  <= `PFRM_RST_FCFG;
      occ_ff  <= `PFRM_RST_FCFG;
      vset_ff <= `PFRM_RST_VSET;
    end else if (wr) begin
      if (a_ctrl) ctrl_ff <= pwdata[1:0];
      if (a_uv)   uvc_ff  <= pwdata;
      if (a_ov)   ovc_ff  <= pwdata;
      if (a_oc)   occ_ff  <= pwdata;
      if (a_vset) vset_ff <= pwdata;
    end
  end
  wire pfrm_fcfg_s uv_c = cfg_of(uvc_ff);
  wire pfrm_fcfg_s ov_c = cfg_of(ovc_ff);
  wire pfrm_fcfg_s oc_c = cfg_of(occ_ff);
  wire logic       en   = ctrl_ff[`PFRM_F_EN];

  // ----------------------------------------------------------------------
  // Undervoltage threshold selection
  // ----------------------------------------------------------------------
  logic [10:0] uv_thr_ff;
  wire logic [10:0] uv_set = uvc_ff[`PFRM_F_UVSET +: 11];
  // Serial value is clamped into the legal window before use.
  wire logic [10:0] uv_ser =
    (uv_set < `PFRM_UV_MIN) ? `PFRM_UV_MIN :
    (uv_set > `PFRM_UV_MAX) ? `PFRM_UV_MAX : uv_set;
  wire logic [10:0] uv_pin =
    (s_lvl == 2'h0) ? `PFRM_UV_LO   :
    (s_lvl == 2'h1) ? `PFRM_UV_OPEN :
    (s_lvl == 2'h2) ? `PFRM_UV_HI   : res_thr(s_idx);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) uv_thr_ff <= `PFRM_UV_OPEN;
    else uv_thr_ff <= ctrl_ff[`PFRM_F_UVOVR] ? uv_ser : uv_pin;
  end
  assign uv_threshold = uv_thr_ff;

  // ----------------------------------------------------------------------
  // Sequencer and fault engine
  // ----------------------------------------------------------------------
  pfrm_state_e st_ff;
  pfrm_state_e nxt_st;
  logic [23:0] cnt_ff;
  logic [7:0]  fdly_ff;
  logic [3:0]  retry_ff;
  logic [1:0]  cause_ff;
  logic        crow_ff;
  logic        pg_ff;
  logic [11:0] pre_ff;
  logic [11:0] ref_ff;
  wire logic [11:0] tgt  = vset_ff[`PFRM_F_TGT +: 12];
  wire logic [19:0] pprd = 20'(tgt) * 20'(vset_ff[`PFRM_F_PCT +: 8]);
  // Overvoltage limit is target plus the configured percentage.
  wire logic [13:0] ov_lim = 14'(tgt) + 14'(pprd / `PFRM_PCT_DIV);
  wire logic ov_f   = 14'(vs) > ov_lim;
  // Read live: pre_ff is only loaded at the end of SAMPLE, too late here.
  wire logic pre_hi = 14'(vs) > ov_lim;
  wire logic [11:0] ramp_v =
    12'((36'(tgt) * 36'(cnt_ff)) / 36'(RAMP_CYC));
  // Cause: 1 undervoltage, 2 overvoltage, 3 overcurrent.
  wire logic t_ov = trips(ov_f, ov_c, fdly_ff);
  wire logic t_oc = trips(oc_f, oc_c, fdly_ff);
  wire logic t_uv = trips(uv_f, uv_c, fdly_ff);
  wire logic [1:0] t_cause = t_ov ? 2'h2 : t_oc ? 2'h3 : 2'h1;
  wire pfrm_fcfg_s c_cfg = (cause_ff == 2'h2) ? ov_c :
                           (cause_ff == 2'h3) ? oc_c : uv_c;
  wire logic c_flt = (cause_ff == 2'h2) ? ov_f :
                     (cause_ff == 2'h3) ? oc_f : uv_f;
  wire logic retry_md = (c_cfg.mode == PFRM_R_RETRYN) ||
                        (c_cfg.mode == PFRM_R_RETRYI);
  wire logic [7:0] wait_dly = retry_md ? c_cfg.dly : 8'h00;
  wire logic dly_flt = (uv_f && uv_c.mode == PFRM_R_DELAY) ||
                       (oc_f && oc_c.mode == PFRM_R_DELAY) ||
                       (ov_f && ov_c.mode == PFRM_R_DELAY);
  wire logic uv_ok = !uv_f || (uv_c.mode == PFRM_R_IGNORE);
  wire logic run_st = (st_ff == PFRM_RAMP) || (st_ff == PFRM_RUN);

  // Next state; disable from software always wins.
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      PFRM_OFF:    if (uv_ok) nxt_st = PFRM_SAMPLE;
      PFRM_SAMPLE: nxt_st = pre_hi ? PFRM_SHUT : PFRM_DELAY;
      PFRM_DELAY:  if (cnt_ff >= 24'(TON_CYC)) nxt_st = PFRM_RAMP;
      PFRM_RAMP, PFRM_RUN: begin
        if (t_ov || t_oc || t_uv) nxt_st = PFRM_SHUT;
        else if (st_ff == PFRM_RAMP && cnt_ff >= 24'(RAMP_CYC))
          nxt_st = PFRM_RUN;
      end
      PFRM_SHUT: begin
        if (c_cfg.mode == PFRM_R_DELAY) nxt_st = PFRM_LATCH;
        else if (!c_flt && cnt_ff >= 24'(wait_dly)) begin
          if (c_cfg.mode == PFRM_R_RETRYN && retry_ff >= c_cfg.lim)
            nxt_st = PFRM_LATCH;
          else nxt_st = PFRM_SAMPLE;
        end
      end
      PFRM_LATCH:  nxt_st = PFRM_LATCH;
      default:     nxt_st = PFRM_OFF;
    endcase
    if (!en) nxt_st = PFRM_OFF;
  end

  // State, shared cycle counter and fault delay counter.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_ff   <= PFRM_OFF;
      cnt_ff  <= 24'h00_0000;
      fdly_ff <= 8'h00;
    end else begin
      st_ff   <= nxt_st;
      cnt_ff  <= (nxt_st != st_ff) ? 24'h00_0000 : cnt_ff + 24'h00_0001;
      fdly_ff <= (run_st && dly_flt) ?
                 ((fdly_ff == 8'hFF) ? fdly_ff : fdly_ff + 8'h01) : 8'h00;
    end
  end

  // Cause, crowbar hold and retry counting.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cause_ff <= 2'h0;
      crow_ff  <= 1'b0;
      retry_ff <= 4'h0;
    end else begin
      if (run_st && nxt_st == PFRM_SHUT) cause_ff <= t_cause;
      if (st_ff == PFRM_SAMPLE && pre_hi) cause_ff <= 2'h2;
      if (nxt_st == PFRM_SHUT && st_ff != PFRM_SHUT)
        crow_ff <= (run_st ? t_ov : 1'b1) &&
                   ov_c.mode == PFRM_R_CROWBAR;
      else if (nxt_st == PFRM_SAMPLE || nxt_st == PFRM_OFF)
        crow_ff <= 1'b0;
      if (nxt_st == PFRM_OFF || st_ff == PFRM_RUN)
        retry_ff <= 4'h0;
      else if (st_ff == PFRM_SHUT && nxt_st == PFRM_SAMPLE &&
               retry_ff != 4'hF)
        retry_ff <= retry_ff + 4'h1;
    end
  end

  // Pre-bias capture, reference ramp and power good.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pre_ff <= 12'h000;
      ref_ff <= 12'h000;
      pg_ff  <= 1'b0;
    end else begin
      if (st_ff == PFRM_SAMPLE) pre_ff <= vs;
      if (st_ff == PFRM_DELAY) ref_ff <= pre_ff;
      else if (st_ff == PFRM_RAMP)
        ref_ff <= (pre_ff < tgt && ramp_v > pre_ff) ? ramp_v : pre_ff;
      else if (st_ff == PFRM_RUN && ref_ff != tgt)
        ref_ff <= (ref_ff > tgt) ? ref_ff - 12'h001 : ref_ff + 12'h001;
      else if (!run_st) ref_ff <= 12'h000;
      pg_ff <= (nxt_st == PFRM_RUN) && !ov_f;
    end
  end
  assign ref_target        = ref_ff;
  assign power_good_output = pg_ff;

  // ----------------------------------------------------------------------
  // Gate drive with adaptive dead time
  // ----------------------------------------------------------------------
  logic       hs_ff;
  logic       ls_ff;
  logic [3:0] dtc_ff;
  logic [3:0] dt_ff;
  logic       dir_ff;
  logic       pwm_q_ff;
  logic [7:0] hon_ff;
  logic [7:0] hprev_ff;
  // Gates drop on the edge that leaves ramp or run, so a fault opens both.
  wire logic run_nxt = (nxt_st == PFRM_RAMP) || (nxt_st == PFRM_RUN);
  wire logic want_hs = run_st && run_nxt && pwm_req && !crow_ff;
  wire logic want_ls = (run_st && run_nxt && !pwm_req) || crow_ff;
  wire logic gap_ok  = dtc_ff >= dt_ff;
  wire logic period  = run_st && pwm_req && !pwm_q_ff;
  wire logic [3:0] dt_step = dir_ff ? dt_ff + 4'h1 : dt_ff - 4'h1;

  // A gate may rise only after the other has been off for dt cycles.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hs_ff  <= 1'b0;
      ls_ff  <= 1'b0;
      dtc_ff <= 4'h0;
    end else begin
      hs_ff  <= want_hs && (hs_ff || (!ls_ff && gap_ok));
      ls_ff  <= want_ls && (ls_ff || (!hs_ff && gap_ok));
      dtc_ff <= (hs_ff || ls_ff) ? 4'h0 :
                (dtc_ff == 4'hF) ? dtc_ff : dtc_ff + 4'h1;
    end
  end
  assign hs_gate = hs_ff;
  assign ls_gate = ls_ff;

  // Hill climb on measured high-side on time; no waveform sensing needed.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dt_ff    <= `PFRM_RST_DT;
      dir_ff   <= 1'b0;
      pwm_q_ff <= 1'b0;
      hon_ff   <= 8'h00;
      hprev_ff <= 8'h00;
    end else begin
      pwm_q_ff <= pwm_req;
      if (period) begin
        hprev_ff <= hon_ff;
        hon_ff   <= 8'h00;
        if (hon_ff > hprev_ff) dir_ff <= !dir_ff;
        if (dt_step >= `PFRM_DT_MIN && dt_step <= `PFRM_DT_MAX)
          dt_ff <= dt_step;
      end else if (hs_ff && hon_ff != 8'hFF) begin
        hon_ff <= hon_ff + 8'h01;
      end
    end
  end

  assign stat_w = {1'b0, uv_thr_ff, retry_ff, 2'h0, cause_ff,
                   2'h0, crow_ff, pg_ff, 1'b0, st_ff};

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_pre_hi;
    st_ff == PFRM_SAMPLE && pre_hi && en;
  endsequence
  chk_no_overlap: assert property (!(hs_ff && ls_ff))
    else $error("both gates on");
  chk_dead_gap: assert property ($rose(hs_ff) |-> !$past(ls_ff))
    else $error("no dead time before high gate");
  chk_dt_bounds: assert property
    (dt_ff >= `PFRM_DT_MIN && dt_ff <= `PFRM_DT_MAX)
    else $error("dead time out of bounds");
  chk_strap_low: assert property
    (s_lvl == 2'h0 && !ctrl_ff[1] |=> uv_thr_ff == `PFRM_UV_LO)
    else $error("low strap not 3 V");
  chk_uv_override: assert property
    (ctrl_ff[1] |=> uv_thr_ff >= `PFRM_UV_MIN &&
     uv_thr_ff <= `PFRM_UV_MAX) else $error("serial threshold range");
  chk_pg_ov: assert property (ov_f |=> !pg_ff)
    else $error("power good held in overvoltage");
  chk_crowbar_hs: assert property (crow_ff |-> !hs_ff ##1 !hs_ff)
    else $error("high gate on during crowbar");
  chk_prebias_ov: assert property
    (s_pre_hi |=> st_ff == PFRM_SHUT && cause_ff == 2'h2)
    else $error("pre-bias overvoltage not flagged");
  chk_uv_ignore: assert property
    (st_ff == PFRM_RUN && en && uv_c.mode == PFRM_R_IGNORE &&
     !t_ov && !t_oc |=> st_ff == PFRM_RUN)
    else $error("ignored undervoltage stopped run");
endmodule // pfrm_top

// ===== pfrm_stage_model.sv
// Behavioural power stage and output load seen by the fault manager.
`timescale 1ns/10ps
module pfrm_stage_model
  import pfrm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        hs_gate,
  input  wire logic        ls_gate,
  input  wire logic [11:0] out_level,
  output logic      [11:0] output_sense_input,
  output logic      [15:0] shoot_cnt
);
  // ----------------------------------------------------------------------
  // Load voltage and shoot-through watch.
  // ----------------------------------------------------------------------
  initial output_sense_input = 12'h000;
  initial shoot_cnt = 16'h0000;
  // The bench commands the load level; the sense path lags one cycle.
  always @(posedge clk_sys) begin
    output_sense_input <= out_level;
  end
  // Both switches on would short the input, so every such cycle counts.
  always @(posedge clk_sys) begin
    if (hs_gate && ls_gate) begin
      shoot_cnt <= shoot_cnt + 16'h0001;
    end
  end
endmodule // pfrm_stage_model

// ===== test_power_fault_response_manager.sv
// Self-checking bench of the fault manager with a power stage model.
`timescale 1ns/10ps
module test_power_fault_response_manager
  import pfrm_pkg::*;
;
  logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, uv_fault_in = 0, oc_fault_in = 0, pwm_req = 0;
  logic [1:0] strap = 2'h1;
  logic [4:0] res_idx = 5'h00;
  logic [11:0] sense, lvl = 12'h000, ref_target;
  logic [15:0] shoot_cnt;
  logic hs_gate, ls_gate, power_good_output;
  logic [10:0] uv_threshold;
  logic [63:0] notes[$];
  int failures = 0, checks_done = 0, seed = 32'h7cb5, cyc, t0;
  // ----------------------------------------------------------------------
  // Clock, design and load model.
  // ----------------------------------------------------------------------
  always #12.5 clk_sys = ~clk_sys;
  pfrm_top #(.TON_CYC(20), .RAMP_CYC(16)) u_pfrm_top (
    .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .input_undervoltage_threshold_strap(strap), .strap_res_idx(res_idx),
    .uv_fault_in(uv_fault_in), .oc_fault_in(oc_fault_in),
    .output_sense_input(sense), .pwm_req(pwm_req), .hs_gate(hs_gate),
    .ls_gate(ls_gate), .power_good_output(power_good_output),
    .ref_target(ref_target), .uv_threshold(uv_threshold));
  pfrm_stage_model u_pfrm_stage_model (.clk_sys(clk_sys),
    .hs_gate(hs_gate), .ls_gate(ls_gate), .out_level(lvl),
    .output_sense_input(sense), .shoot_cnt(shoot_cnt));
  // ----------------------------------------------------------------------
  // Checking helpers.
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Read notes hold mask and value; compared when the access completes.
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite && notes.size() > 0) begin
      chk("prdata", notes[0][31:0], prdata & notes[0][63:32]);
      void'(notes.pop_front());
    end
  end
  // A gate may only rise after the other was off the cycle before.
  always @(posedge clk_sys) begin
    if (resetn && $rose(hs_gate)) chk("hs_gap", 0, $past(ls_gate));
    if (resetn && $rose(ls_gate)) chk("ls_gap", 0, $past(hs_gate));
    pwm_req <= 1'($random(seed));
  end
  // Watchdog sized well above the scripted run.
  initial begin
    #(25 * 40000);
    failures++;
    final_report();
  end
  // ----------------------------------------------------------------------
  // Bus and wait tasks.
  // ----------------------------------------------------------------------
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    chk("pslverr", a > 8'h14, pslverr);
    psel <= 0; penable <= 0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    notes.push_back({m, e});
    apb(a, 1'b0, 32'h0000_0000);
  endtask
  task automatic wt(input logic want, input int mx);
    cyc = 0;
    while (power_good_output !== want && cyc < mx) begin
      @(posedge clk_sys); cyc++;
    end
    chk("power_good", want, power_good_output);
  endtask
  task automatic hold(input int n); repeat (n) @(posedge clk_sys); endtask
  task automatic fault_cycle(input int ov, input logic [31:0] cfg);
    apb(8'h0C, 1, cfg);
    oc_fault_in <= ov[0]; uv_fault_in <= ov[1];
    wt(0, 30); chk("gates_off", 0, hs_gate | ls_gate);
    oc_fault_in <= 0; uv_fault_in <= 0;
    wt(1, 300);
  endtask
  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    hold(4); resetn <= 1; @(posedge clk_sys);
    rd(8'h10, 32'hFFFF_FFFF, 32'h000F_0400); rd(8'h00, 32'hFFFF_FFFF, 0);
    rd(8'h18, 32'hFFFF_FFFF, 0); $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      strap <= (i < 3) ? i[1:0] : 2'h3; res_idx <= (i == 3) ? 5'd0 : 5'd18;
      hold(6);
      chk("uv_thr", i==0 ? 11'h12C : i==1 ? 11'h1C2 : i==2 ? 11'h438 :
          i==3 ? 11'h11D : 11'h640, uv_threshold);
    end
    apb(8'h04, 1, 32'h0200_0000); apb(8'h00, 1, 32'h0000_0002);
    hold(3); chk("uv_override", 11'h200, uv_threshold);
    apb(8'h04, 1, 0); $display("test threshold done");
    for (int i = 0; i < 3; i++) begin
      apb(8'h00, 1, 0); lvl <= i==0 ? 12'h000 : i==1 ? 12'h200 : 12'h480;
      hold(4); apb(8'h00, 1, 1); t0 = cyc; wt(1, 300);
      if (i > 0) chk("ramp_len", t0, cyc);
      hold(200); chk("ref_final", 12'h400, ref_target);
    end
    apb(8'h00, 1, 0); lvl <= 12'h4A0; hold(4); apb(8'h00, 1, 1); hold(100);
    chk("pg_prebias_ov", 0, power_good_output);
    rd(8'h14, 32'h0000_3000, 32'h0000_2000);
    lvl <= 12'h400; wt(1, 300);
    lvl <= 12'h4A0; wt(0, 10); chk("ov_gates", 0, hs_gate | ls_gate);
    lvl <= 12'h400; wt(1, 300);
    apb(8'h08, 1, 5); lvl <= 12'h4A0; hold(30);
    chk("crowbar", 2'b01, {hs_gate, ls_gate});
    lvl <= 12'h400; wt(1, 300); apb(8'h08, 1, 0); $display("test ov done");
    fault_cycle(2, 0);
    apb(8'h04, 1, 1); uv_fault_in <= 1; hold(60);
    chk("uv_ignore", 1, power_good_output);
    uv_fault_in <= 0; apb(8'h04, 1, 32'h0000_1002); uv_fault_in <= 1;
    hold(6); chk("uv_dly_run", 1, power_good_output);
    hold(40); uv_fault_in <= 0; hold(100);
    chk("uv_dly_off", 0, power_good_output);
    apb(8'h04, 1, 0); apb(8'h00, 1, 0); apb(8'h00, 1, 1); wt(1, 300);
    apb(8'h0C, 1, 1); oc_fault_in <= 1; hold(60);
    chk("oc_ignore", 1, power_good_output); oc_fault_in <= 0;
    fault_cycle(1, 0);
    fault_cycle(1, 32'h0000_0804);
    apb(8'h0C, 1, 32'h0000_0423); wt(1, 300);
    // Each later pulse lands in the ramp of a restart, so restarts fail.
    for (int i = 0; i < 3; i++) begin
      oc_fault_in <= 1; hold(6); oc_fault_in <= 0; hold(30);
    end
    hold(200); chk("oc_latched", 0, power_good_output);
    rd(8'h14, 32'h000F_007F, 32'h0002_0040);
    chk("shoot", 0, shoot_cnt); $display("test faults done");
    final_report();
  end
endmodule // test_power_fault_response_manager
